// ==== rtl/ttc_top.sv ====
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - rightmost display segment shows a rotating bar while the logic runs.
// - left three segments show link state, or error with its number.
// - during boot all four segments show bus letter and node number.
// - fatal error halts the command engine and flashes the whole display.
// - LED turns orange when a tag arrives, changes once transfer works.
// - LED green when tag answers correctly, red after an erroneous exchange.
// - LED back to orange when exchange ends, off when tag leaves.
// - with tag present, host commands run at once, result returned.
// - commands arriving with no tag are stored and run on arrival.
// - stored commands are single-shot or repeating for every later tag.
// - stored commands all run before any direct command.
// - every packet carries byte parity and a longitudinal check byte.
// - a parity failure resends the whole packet.
// - each exchange not aborted ends with a sign-off packet to the tag.
// - unexpected tag departure aborts the exchange and returns the engine to idle.
// - departure without any write started raises no error.
// - departure after a write was started changes the link state to error.
module ttc_top import ttc_pkg::*; #(
  parameter int QDEPTH = 4,
  parameter int BOOT_CYCLES = BOOT_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int SPIN_CYCLES = SPIN_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int FLASH_CYCLES = FLASH_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter logic [7:0] BUS_CODE = 8'h42, // arbitrary value
  parameter logic [11:0] NODE_RESET = 12'h001
) (
  input wire logic CLK, // system clock
  input wire logic RESET, // synchronous reset, active high
  input wire logic [3:0] ADDR, // register address
  input wire logic [31:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after RD
  input wire logic TAG_PRESENT, // tag inside rf_field
  input wire logic TX_READY, // link takes TX_WORD
  output logic TX_VALID, // word to tag valid
  output logic [8:0] TX_WORD, // parity bit and byte to tag
  input wire logic RX_VALID, // word from tag valid
  input wire logic [8:0] RX_WORD, // parity bit and byte from tag
  input wire logic FATAL, // fatal system fault
  output ttc_led_t LED, // status LED colour
  output ttc_disp_t DISP // four display characters, seg0 leftmost
);
  localparam int QW = $clog2(QDEPTH);

  generate
    if (QDEPTH < 2 || QDEPTH > 8) begin : g_bad_depth
      $error("QDEPTH must be 2 to 8");
    end
    if (BOOT_CYCLES < 1 || SPIN_CYCLES < 1 || FLASH_CYCLES < 1) begin : g_bad_time
      $error("display timing counts must be at least one");
    end
  endgenerate

  typedef enum {E_IDLE, E_SEND, E_RSP, E_CHECK} ttc_eng_t;

  ttc_eng_t eng;
  ttc_cmd_t cur, pend_cmd, host_cmd;
  ttc_cmd_t q_cmd [QDEPTH];
  logic [QDEPTH-1:0] q_valid, q_done;
  logic [QW-1:0] q_sel, q_free, cur_idx;
  logic q_hit, q_has_free, cur_q, pend, signoff, in_exch, data_mod;
  logic [2:0] tx_idx;
  logic [1:0] rx_idx;
  logic [7:0] rx_stat, rx_data, rx_lrc, tx_byte, tx_lrc;
  logic rx_bad, rx_par, tx_par, pkt_ok, fin_cmd;
  logic [3:0] retries, retry_max, err_num;
  logic [11:0] node;
  logic link_err, ovf, fatal_seen, tag_q, good_seen, ex_err;
  logic [7:0] res_data;
  logic res_valid, res_err;
  logic [31:0] boot_cnt, spin_cnt, flash_cnt;
  logic [1:0] spin_ph;
  logic flash_ph;
  ttc_link_t link;
  logic host_cmd_wr, host_ctrl_wr, tag_rise, depart;

  assign host_cmd_wr = WR && (ADDR == REG_CMD);
  assign host_ctrl_wr = WR && (ADDR == REG_CTRL);
  assign host_cmd = '{rep: WDATA[CMD_REP_BIT], wr: WDATA[CMD_WR_BIT],
                      addr: WDATA[CMD_ADDR_LSB +: 16], data: WDATA[CMD_DATA_LSB +: 8]};
  assign tag_rise = TAG_PRESENT && !tag_q;
  assign depart = !TAG_PRESENT && (eng != E_IDLE || in_exch);

  ////////////////////////////////////////////////////////////////////////////////
  // pick the lowest stored command still to run, and the lowest free slot
  always_comb begin
    q_hit = 1'b0;
    q_sel = '0;
    q_has_free = 1'b0;
    q_free = '0;
    for (int i = QDEPTH - 1; i >= 0; i--) begin
      if (q_valid[i] && !q_done[i]) begin
        q_hit = 1'b1;
        q_sel = QW'(i);
      end
      if (!q_valid[i]) begin
        q_has_free = 1'b1;
        q_free = QW'(i);
      end
    end
  end

  // stored commands; stores only happen with no tag, so they never meet a finish
  always_ff @(posedge CLK) begin
    if (RESET) begin
      q_valid <= '0;
      q_done <= '0;
    end else begin
      if (tag_rise) begin
        q_done <= '0; // repeating entries become due again for each new tag
      end
      if (fin_cmd && cur_q) begin
        if (cur.rep) begin
          q_done[cur_idx] <= 1'b1;
        end else begin
          q_valid[cur_idx] <= 1'b0; // single-shot entry is spent
        end
      end
      if (host_ctrl_wr && WDATA[CTRL_CLRQ_BIT]) begin
        q_valid <= '0;
      end
      if (host_cmd_wr && !TAG_PRESENT && q_has_free) begin
        q_valid[q_free] <= 1'b1;
        q_cmd[q_free] <= host_cmd;
      end
    end
  end

  // one direct command may wait while stored ones run
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pend <= 1'b0;
      pend_cmd <= '0;
      ovf <= 1'b0;
    end else begin
      if (fin_cmd && !cur_q) begin
        pend <= 1'b0;
      end
      if (host_ctrl_wr && WDATA[CTRL_CLRERR_BIT]) begin
        ovf <= 1'b0;
      end
      if (host_cmd_wr && TAG_PRESENT) begin
        if (!pend || (fin_cmd && !cur_q)) begin
          pend <= 1'b1;
          pend_cmd <= host_cmd;
        end else begin
          ovf <= 1'b1;
        end
      end else if (host_cmd_wr && !q_has_free) begin
        ovf <= 1'b1; // lost command is reported, never silently queued over
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // packet words: op, address high, address low, data, check byte
  always_comb begin
    case (tx_idx)
      3'h0: tx_byte = signoff ? OP_SIGNOFF : (cur.wr ? OP_WRITE : OP_READ);
      3'h1: tx_byte = cur.addr[15:8];
      3'h2: tx_byte = cur.addr[7:0];
      3'h3: tx_byte = cur.data;
      default: tx_byte = tx_lrc; // longitudinal check byte
    endcase
  end
  assign tx_lrc = (signoff ? OP_SIGNOFF : (cur.wr ? OP_WRITE : OP_READ))
                  ^ cur.addr[15:8] ^ cur.addr[7:0] ^ cur.data;

  ttc_parity u_tx_par (
    .BYTE(tx_byte),
    .PAR(tx_par)
  );
  ttc_parity u_rx_par (
    .BYTE(RX_WORD[7:0]),
    .PAR(rx_par)
  );

  assign TX_VALID = (eng == E_SEND);
  assign TX_WORD = {tx_par, tx_byte}; // transverse parity on each word
  assign pkt_ok = !rx_bad && (rx_lrc == 8'h00);
  assign fin_cmd = (eng == E_CHECK) && pkt_ok && !signoff && TAG_PRESENT;

  ////////////////////////////////////////////////////////////////////////////////
  // command engine: stored commands first, then direct, then sign-off
  always_ff @(posedge CLK) begin
    if (RESET) begin
      eng <= E_IDLE;
      cur <= '0;
      cur_q <= 1'b0;
      cur_idx <= '0;
      signoff <= 1'b0;
      in_exch <= 1'b0;
      data_mod <= 1'b0;
      tx_idx <= '0;
      rx_idx <= '0;
      rx_stat <= '0;
      rx_data <= '0;
      rx_lrc <= '0;
      rx_bad <= 1'b0;
      retries <= '0;
      link_err <= 1'b0;
      err_num <= ERRN_NONE;
    end else begin
      if (host_ctrl_wr && WDATA[CTRL_CLRERR_BIT]) begin
        link_err <= 1'b0;
        err_num <= ERRN_NONE;
      end
      if (depart) begin
        eng <= E_IDLE;
        in_exch <= 1'b0;
        data_mod <= 1'b0;
        signoff <= 1'b0;
        if (data_mod) begin
          link_err <= 1'b1; // early departure after a write
          err_num <= ERRN_DEPART;
        end // nothing written means nothing lost: no error
      end else begin
        case (eng)
          E_IDLE: begin
            tx_idx <= '0;
            retries <= '0;
            if (TAG_PRESENT && !link_err && !fatal_seen) begin // halted on fatal
              if (q_hit) begin
                cur <= q_cmd[q_sel]; // stored commands win over direct
                cur_q <= 1'b1;
                cur_idx <= q_sel;
                signoff <= 1'b0;
                in_exch <= 1'b1;
                data_mod <= data_mod | q_cmd[q_sel].wr;
                eng <= E_SEND;
              end else if (pend) begin
                cur <= pend_cmd;
                cur_q <= 1'b0;
                signoff <= 1'b0;
                in_exch <= 1'b1;
                data_mod <= data_mod | pend_cmd.wr;
                eng <= E_SEND;
              end else if (in_exch) begin
                signoff <= 1'b1; // close the exchange
                eng <= E_SEND;
              end
            end
          end
          E_SEND: begin
            if (TX_READY) begin
              if (tx_idx == TX_LAST) begin
                rx_idx <= '0;
                rx_lrc <= '0;
                rx_bad <= 1'b0;
                eng <= E_RSP;
              end else begin
                tx_idx <= tx_idx + 3'h1;
              end
            end
          end
          E_RSP: begin
            if (RX_VALID) begin
              rx_lrc <= rx_lrc ^ RX_WORD[7:0];
              rx_bad <= rx_bad | (rx_par != RX_WORD[8]);
              if (rx_idx == 2'h0) begin
                rx_stat <= RX_WORD[7:0];
              end
              if (rx_idx == 2'h1) begin
                rx_data <= RX_WORD[7:0];
              end
              if (rx_idx == RX_LAST) begin
                eng <= E_CHECK;
              end else begin
                rx_idx <= rx_idx + 2'h1;
              end
            end
          end
          E_CHECK: begin
            tx_idx <= '0;
            if (pkt_ok) begin
              eng <= E_IDLE;
              if (signoff) begin
                signoff <= 1'b0;
                in_exch <= 1'b0;
                data_mod <= 1'b0;
              end
            end else if (retries == retry_max) begin
              link_err <= 1'b1; // resend budget spent: abort
              err_num <= ERRN_RETRY;
              in_exch <= 1'b0;
              signoff <= 1'b0;
              eng <= E_IDLE;
            end else begin
              retries <= retries + 4'h1;
              eng <= E_SEND; // resend the whole packet
            end
          end
          default: eng <= E_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // results for the host and LED history; new result beats the read-clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      res_data <= '0;
      res_valid <= 1'b0;
      res_err <= 1'b0;
      good_seen <= 1'b0;
      ex_err <= 1'b0;
      tag_q <= 1'b0;
      fatal_seen <= 1'b0;
      retry_max <= RETRY_RESET;
      node <= NODE_RESET;
    end else begin
      tag_q <= TAG_PRESENT;
      fatal_seen <= fatal_seen | FATAL;
      if (host_ctrl_wr) begin
        retry_max <= WDATA[CTRL_RETRY_LSB +: 4]; // steers the resend cap
        node <= WDATA[CTRL_NODE_LSB +: 12];
      end
      if (RD && ADDR == REG_CMD) begin
        res_valid <= 1'b0;
      end
      if (tag_rise) begin
        good_seen <= 1'b0;
        ex_err <= 1'b0;
      end
      if (fin_cmd) begin
        res_data <= rx_data;
        res_err <= rx_stat[TAG_ERR_BIT];
        res_valid <= 1'b1;
        good_seen <= 1'b1;
        ex_err <= ex_err | rx_stat[TAG_ERR_BIT];
      end
      if (link_err) begin
        ex_err <= 1'b1;
      end
    end
  end

  // colour follows tag presence and how the exchange went
  always_comb begin
    if (!TAG_PRESENT) begin
      LED = LED_OFF;
    end else if (ex_err) begin
      LED = LED_RED;
    end else if (in_exch && good_seen) begin
      LED = LED_GREEN;
    end else begin
      LED = LED_ORANGE; // arrival and end of exchange
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register reads, data in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= '0;
    end else begin
      RDATA <= '0;
      if (RD) begin
        case (ADDR)
          REG_CMD: RDATA <= {22'h000000, res_err, res_valid, res_data};
          REG_CTRL: RDATA <= {16'h0000, node, retry_max};
          REG_STATUS: RDATA <= {22'h000000, fatal_seen, ovf, err_num, TAG_PRESENT,
                                (eng != E_IDLE), link};
          default: RDATA <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display timers; the bar stops with the logic on a fatal error
  always_ff @(posedge CLK) begin
    if (RESET) begin
      boot_cnt <= 32'(BOOT_CYCLES);
      spin_cnt <= '0;
      flash_cnt <= '0;
      spin_ph <= '0;
      flash_ph <= 1'b0;
    end else begin
      if (boot_cnt != '0) begin
        boot_cnt <= boot_cnt - 32'h1;
      end
      if (spin_cnt == 32'(SPIN_CYCLES - 1)) begin
        spin_cnt <= '0;
        if (!fatal_seen) begin
          spin_ph <= spin_ph + 2'h1;
        end
      end else begin
        spin_cnt <= spin_cnt + 32'h1;
      end
      if (flash_cnt == 32'(FLASH_CYCLES - 1)) begin
        flash_cnt <= '0;
        flash_ph <= ~flash_ph;
      end else begin
        flash_cnt <= flash_cnt + 32'h1;
      end
    end
  end

  always_comb begin
    if (link_err) begin
      link = LINK_ERR;
    end else if (!TAG_PRESENT) begin
      link = LINK_WAIT;
    end else if (q_hit || (eng != E_IDLE && cur_q && !signoff)) begin
      link = LINK_PRE;
    end else begin
      link = LINK_CON;
    end
  end

  // display register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DISP <= '{CH_BLANK, CH_BLANK, CH_BLANK, CH_BLANK};
    end else if (boot_cnt != '0) begin
      DISP <= '{BUS_CODE, CH_ZERO + {4'h0, node[11:8]}, CH_ZERO + {4'h0, node[7:4]},
                CH_ZERO + {4'h0, node[3:0]}};
    end else if (fatal_seen && flash_ph) begin
      DISP <= '{CH_BLANK, CH_BLANK, CH_BLANK, CH_BLANK}; // both areas flash
    end else begin
      case (link)
        LINK_ERR: begin
          DISP.seg0 <= CH_E;
          DISP.seg1 <= CH_ZERO;
          DISP.seg2 <= CH_ZERO + {4'h0, err_num};
        end
        LINK_PRE: {DISP.seg0, DISP.seg1, DISP.seg2} <= {CH_P, CH_R, CH_E};
        LINK_CON: {DISP.seg0, DISP.seg1, DISP.seg2} <= {CH_C, CH_O, CH_N};
        default: {DISP.seg0, DISP.seg1, DISP.seg2} <= {CH_W, CH_A, CH_I};
      endcase
      case (spin_ph)
        2'h0: DISP.seg3 <= CH_BAR0;
        2'h1: DISP.seg3 <= CH_BAR1;
        2'h2: DISP.seg3 <= CH_BAR2;
        default: DISP.seg3 <= CH_BAR3;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ttc_pkg.sv ====
package ttc_pkg;

  // clock and display timing, each time in its own unit
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int BOOT_TIME_MS = 2000;
  localparam int SPIN_TIME_MS = 100;
  localparam int FLASH_TIME_MS = 250;

  ////////////////////////////////////////////////////////////////////////////////
  // register port map
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;

  // command register fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WR_BIT = 24;
  localparam int CMD_REP_BIT = 25;
  localparam int RES_VALID_BIT = 8;
  localparam int RES_ERR_BIT = 9;

  // control register fields
  localparam int CTRL_RETRY_LSB = 0;
  localparam int CTRL_NODE_LSB = 4;
  localparam int CTRL_CLRERR_BIT = 16;
  localparam int CTRL_CLRQ_BIT = 17;
  localparam logic [3:0] RETRY_RESET = 4'h3;

  // status register fields
  localparam int STAT_LINK_LSB = 0;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_TAG_BIT = 3;
  localparam int STAT_ERRN_LSB = 4;
  localparam int STAT_OVF_BIT = 8;
  localparam int STAT_FATAL_BIT = 9;

  ////////////////////////////////////////////////////////////////////////////////
  // tag packet format
  localparam logic [7:0] OP_READ = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SIGNOFF = 8'h0F;
  localparam logic [2:0] TX_LAST = 3'h4;
  localparam logic [1:0] RX_LAST = 2'h2;
  localparam int TAG_ERR_BIT = 0;

  // error numbers shown on the display
  localparam logic [3:0] ERRN_NONE = 4'h0;
  localparam logic [3:0] ERRN_DEPART = 4'h1;
  localparam logic [3:0] ERRN_RETRY = 4'h2;

  // display characters
  localparam logic [7:0] CH_BLANK = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_BAR0 = 8'h7C;
  localparam logic [7:0] CH_BAR1 = 8'h2F;
  localparam logic [7:0] CH_BAR2 = 8'h2D;
  localparam logic [7:0] CH_BAR3 = 8'h5C;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_W = 8'h57;

  typedef enum logic [1:0] {LED_OFF, LED_ORANGE, LED_GREEN, LED_RED} ttc_led_t;
  typedef enum logic [1:0] {LINK_WAIT, LINK_PRE, LINK_CON, LINK_ERR} ttc_link_t;

  typedef struct packed {
    logic rep;
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } ttc_cmd_t;

  typedef struct packed {
    logic [7:0] seg0;
    logic [7:0] seg1;
    logic [7:0] seg2;
    logic [7:0] seg3;
  } ttc_disp_t;

endpackage

// ==== rtl/ttc_parity.sv ====
`timescale 1ns/100ps
`default_nettype none

// odd transverse parity of one packet byte
module ttc_parity (
  input wire logic [7:0] BYTE, // byte to protect
  output logic PAR // parity bit making the nine-bit word odd
);
  assign PAR = ~(^BYTE);
endmodule

`default_nettype wire

// ==== tb/ttc_tag_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// behavioural mobile_tag on the far side of the rf_field link
module ttc_tag_model import ttc_pkg::*; (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic present, // tag in field
  input wire logic tx_valid, // head word valid
  input wire logic [8:0] tx_word, // head word
  input wire logic slow, // stall odd cycles
  input wire logic hold, // withhold replies
  input wire logic bad_ld, // load bad_num
  input wire logic [3:0] bad_num, // replies to spoil
  output logic tx_ready, // word taken
  output logic rx_valid, // reply valid
  output logic [8:0] rx_word, // reply word
  output logic comm_err, // left unsigned
  output int pkt_cnt, // packets taken
  output int so_cnt, // sign-offs
  output int wr_cnt // writes
);
  logic [7:0] pk [5];
  logic [7:0] rb [3];
  logic [7:0] mem [16];
  logic [7:0] ops [32];
  logic [7:0] st;
  logic [3:0] bad;
  logic cyc, open, perr;
  int n, rc;
  ////////////////////////////////////////////////////////////////////////////////
  // one packet at a time; slow mode stalls every other cycle
  assign tx_ready = (n < 5) && (!slow || cyc);
  assign st = {7'h00, perr || ((pk[0] ^ pk[1] ^ pk[2] ^ pk[3] ^ pk[4]) != 8'h00)};
  // intake, memory and reply; an idle reply line toggles so no stale word shows
  always_ff @(posedge clk) begin
    cyc <= ~cyc;
    rx_valid <= 1'b0;
    rx_word <= ~rx_word;
    if (bad_ld) bad <= bad_num;
    if (rst) begin
      {n, rc, pkt_cnt, so_cnt, wr_cnt} <= '0;
      {open, perr, comm_err, cyc, bad} <= '0;
      rx_word <= 9'h000;
      for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
    end else if (!present) begin
      n <= 0;
      rc <= 0;
      if (open) comm_err <= 1'b1;
      open <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      pk[n] <= tx_word[7:0];
      if (tx_word[8] != ~^tx_word[7:0]) perr <= 1'b1;
      n <= n + 1;
    end else if (n == 5 && rc == 0) begin
      rb[0] <= st;
      rb[1] <= mem[pk[2][3:0]];
      rb[2] <= st ^ mem[pk[2][3:0]];
      ops[pkt_cnt[4:0]] <= pk[0];
      pkt_cnt <= pkt_cnt + 1;
      perr <= 1'b0;
      rc <= 1;
      open <= (pk[0] != OP_SIGNOFF);
      so_cnt <= so_cnt + int'(pk[0] == OP_SIGNOFF);
      if (pk[0] == OP_WRITE) mem[pk[2][3:0]] <= pk[3];
      wr_cnt <= wr_cnt + int'(pk[0] == OP_WRITE);
    end else if (rc > 0 && !hold) begin
      rx_valid <= 1'b1;
      rx_word <= {(~^rb[rc-1]) ^ (rc == 1 && bad != 4'h0), rb[rc-1]};
      if (rc == 1 && bad != 4'h0) bad <= bad - 4'h1;
      rc <= (rc == 3) ? 0 : rc + 1;
      n <= (rc == 3) ? 0 : n;
    end
  end
endmodule
`default_nettype wire

// ==== tb/ttc_top_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the controller
module ttc_top_asserts import ttc_pkg::*; #(
  parameter logic [7:0] BUS_CODE = 8'h42 // arbitrary value
) (
  input wire logic CLK, // clock
  input wire logic RESET, // reset
  input wire logic TAG_PRESENT, // tag in field
  input wire logic TX_READY, // link takes word
  input wire logic TX_VALID, // word valid
  input wire logic [8:0] TX_WORD, // word to tag
  input wire logic FATAL, // fatal fault
  input wire ttc_led_t LED, // led colour
  input wire ttc_disp_t DISP // display
);
  logic fatal_seen;
  // fatal is sticky inside the design, so mirror it
  always_ff @(posedge CLK) begin
    if (RESET) fatal_seen <= 1'b0;
    else if (FATAL) fatal_seen <= 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_stall;
    TX_VALID && !TX_READY && TAG_PRESENT;
  endsequence
  sequence s_bar0;
    !fatal_seen && DISP.seg3 == CH_BAR0;
  endsequence
  property p_tx_hold;
    s_stall |=> TX_VALID && $stable(TX_WORD);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped");
  property p_parity;
    TX_VALID |-> TX_WORD[8] == ~^TX_WORD[7:0];
  endproperty
  a_parity: assert property (p_parity) else $error("bad tx parity");
  property p_led_off;
    !TAG_PRESENT |-> LED == LED_OFF;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led lit without tag");
  property p_led_on;
    TAG_PRESENT |-> LED != LED_OFF;
  endproperty
  a_led_on: assert property (p_led_on) else $error("led dark with tag");
  property p_no_tx;
    !TAG_PRESENT ##1 !TAG_PRESENT |-> !TX_VALID;
  endproperty
  a_no_tx: assert property (p_no_tx) else $error("sending without tag");
  property p_boot;
    $fell(RESET) |-> ##[1:2] DISP.seg0 == BUS_CODE;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot text");
  property p_bar;
    s_bar0 |-> ##[1:6] (DISP.seg3 == CH_BAR1 || fatal_seen);
  endproperty
  a_bar: assert property (p_bar) else $error("bar not turning");
  property p_fatal;
    $rose(fatal_seen) |-> ##[0:14] DISP == {4{CH_BLANK}};
  endproperty
  a_fatal: assert property (p_fatal) else $error("no flashing");
endmodule
bind ttc_top ttc_top_asserts #(.BUS_CODE(BUS_CODE)) u_ttc_top_asserts (.CLK(CLK),
  .RESET(RESET), .TAG_PRESENT(TAG_PRESENT), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
  .TX_WORD(TX_WORD), .FATAL(FATAL), .LED(LED), .DISP(DISP));
`default_nettype wire

// ==== tb/test_tag_transaction_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_tag_transaction_controller import ttc_pkg::*;;
  localparam logic [7:0] BUS = 8'h42; // arbitrary value
  localparam logic [7:0] OPS [4] = '{OP_WRITE, OP_READ, OP_READ, OP_SIGNOFF};
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, TAG = 0, FATAL = 0;
  logic slow = 0, hold = 0, bad_ld = 0, TX_READY, TX_VALID, RX_VALID, comm_err;
  logic [3:0] ADDR = 0, bad_num = 0;
  logic [31:0] WDATA = 0, RDATA, r, seed = 32'hC07C;
  logic [8:0] TX_WORD, RX_WORD;
  logic [15:0] a;
  logic [7:0] d;
  ttc_led_t LED;
  ttc_disp_t DISP;
  int pkt_cnt, so_cnt, wr_cnt, error_cnt = 0, tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 CLK = ~CLK;
  // short boot and display counts keep the run brief
  ttc_top #(.QDEPTH(4), .BOOT_CYCLES(20), .SPIN_CYCLES(4), .FLASH_CYCLES(6), .BUS_CODE(BUS),
    .NODE_RESET(12'h001)) u_ttc_top (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TAG_PRESENT(TAG), .TX_READY(TX_READY),
    .TX_VALID(TX_VALID), .TX_WORD(TX_WORD), .RX_VALID(RX_VALID), .RX_WORD(RX_WORD),
    .FATAL(FATAL), .LED(LED), .DISP(DISP));
  ttc_tag_model u_ttc_tag_model (.clk(CLK), .rst(RESET), .present(TAG), .tx_valid(TX_VALID),
    .tx_word(TX_WORD), .slow(slow), .hold(hold), .bad_ld(bad_ld), .bad_num(bad_num),
    .tx_ready(TX_READY), .rx_valid(RX_VALID), .rx_word(RX_WORD), .comm_err(comm_err),
    .pkt_cnt(pkt_cnt), .so_cnt(so_cnt), .wr_cnt(wr_cnt));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] cmd(input logic rep, wrt, input logic [15:0] ad, input logic [7:0] dt);
    return {6'h00, rep, wrt, ad, dt};
  endfunction
  function logic [23:0] err_text(input logic [3:0] n);
    return {CH_E, CH_ZERO, CH_ZERO + {4'h0, n}};
  endfunction
  // register port: one-cycle strobes, read data in the following cycle
  task wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge CLK);
    ADDR <= ad;
    WDATA <= dt;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [3:0] ad);
    @(posedge CLK);
    ADDR <= ad;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 r = RDATA;
  endtask
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // bounded wait for sign-off or packet count
  task wt(input logic so, input int n);
    int k;
    k = 0;
    while (((so ? so_cnt : pkt_cnt) < n) && k < 3000) begin
      @(posedge CLK);
      k++;
    end
    `CHK("wait", 1'b1, k < 3000)
    tick(12);
  endtask
  task setbad(input logic [3:0] n);
    @(posedge CLK);
    bad_num <= n;
    bad_ld <= 1'b1;
    @(posedge CLK);
    bad_ld <= 1'b0;
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog far past the run
  initial begin
    repeat (20000) @(posedge CLK);
    `CHK("watchdog", 1'b0, 1'b1)
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    tick(5);
    `CHK("boot", {BUS, CH_ZERO, CH_ZERO, CH_ZERO + 8'h01}, DISP)
    tick(24);
    `CHK("link", {CH_W, CH_A, CH_I}, DISP[31:8])
    r = rnd();
    a = r[15:0];
    d = r[23:16];
    wr(REG_CMD, cmd(0, 1, a, d));
    wr(REG_CMD, cmd(1, 0, a, 8'h00));
    @(posedge CLK) TAG <= 1'b1;
    slow <= 1'b1;
    wr(REG_CMD, cmd(0, 0, a, 8'h00));
    wt(1, 1);
    for (int i = 0; i < 4; i++) `CHK("op", OPS[i], u_ttc_tag_model.ops[i])
    `CHK("mem", d, u_ttc_tag_model.mem[a[3:0]])
    rd(REG_CMD);
    `CHK("res", {1'b1, d}, r[8:0])
    `CHK("led", LED_ORANGE, LED)
    @(posedge CLK) TAG <= 1'b0;
    slow <= 1'b0;
    tick(2);
    `CHK("led", LED_OFF, LED)
    @(posedge CLK) TAG <= 1'b1;
    wt(1, 2);
    `CHK("wrs", 1, wr_cnt)
    `CHK("pkts", 6, pkt_cnt)
    rd(REG_CMD);
    `CHK("rep", 1'b1, r[8])
    setbad(4'h1);
    wr(REG_CMD, cmd(0, 0, a, 8'h00));
    wt(1, 3);
    `CHK("pkts", 9, pkt_cnt)
    rd(REG_CMD);
    `CHK("res", {1'b1, d}, r[8:0])
    wr(REG_CTRL, 32'h0000_0012);
    setbad(4'h7);
    wr(REG_CMD, cmd(0, 0, a, 8'h00));
    wt(0, 12);
    tick(20);
    `CHK("pkts", 12, pkt_cnt)
    rd(REG_STATUS);
    `CHK("st", {ERRN_RETRY, LINK_ERR}, {r[7:4], r[1:0]})
    `CHK("led", LED_RED, LED)
    `CHK("disp", err_text(ERRN_RETRY), DISP[31:8])
    @(posedge CLK) TAG <= 1'b0;
    setbad(4'h0);
    `CHK("comm", 1'b1, comm_err)
    wr(REG_CTRL, 32'h0001_0013);
    @(posedge CLK) TAG <= 1'b1;
    hold <= 1'b1;
    wr(REG_CMD, cmd(0, 0, a, 8'h00));
    wt(0, 13);
    @(posedge CLK) TAG <= 1'b0;
    tick(4);
    rd(REG_STATUS);
    `CHK("errn", ERRN_NONE, r[7:4])
    wr(REG_CMD, cmd(0, 1, a, ~d));
    @(posedge CLK) TAG <= 1'b1;
    wt(0, 14);
    @(posedge CLK) TAG <= 1'b0;
    tick(4);
    rd(REG_STATUS);
    `CHK("st", {ERRN_DEPART, LINK_ERR}, {r[7:4], r[1:0]})
    wr(REG_CTRL, 32'h0003_0013);
    for (int i = 0; i < 5; i++) wr(REG_CMD, cmd(0, 0, a, 8'h00));
    rd(REG_STATUS);
    `CHK("ovf", 1'b1, r[8])
    @(posedge CLK) FATAL <= 1'b1;
    tick(20);
    rd(REG_STATUS);
    `CHK("fatal", 1'b1, r[9])
    print_verdict;
  end
endmodule
`default_nettype wire
